/* File: design/sls_pkg.sv */
// Shared constants, types and register map of the serial link sync controller
package sls_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on APB
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_RX_DATA = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA = 8'h14;

    // Control register fields
    localparam int CTRL_W = 2;
    localparam int CTRL_SOFT_SYNC_BIT = 0;
    localparam int CTRL_LOOPBACK_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Status register fields
    localparam int STAT_LOCK_N_BIT = 0;
    localparam int STAT_SYNC_BIT = 1;
    localparam int STAT_POWERED_BIT = 2;
    localparam int STAT_OE_BIT = 3;

    // Interrupt status and mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_LOST_BIT = 0;
    localparam int IRQ_GAINED_BIT = 1;
    localparam int IRQ_RX_WORD_BIT = 2;
    localparam int IRQ_TX_WORD_BIT = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Framing: clock-high bit, ten data bits, clock-low bit
    localparam int DATA_W = 10;
    localparam int FRAME_W = 12;
    localparam logic [3:0] FRAME_LAST = 4'hB;
    localparam logic [11:0] SYNC_FRAME = 12'hF80;
    localparam int SYNC_MIN_SYMBOLS = 1024;
    localparam int SYNC_CNT_W = 11;
    localparam int LOSS_FRAMES = 4;
    localparam int RELOCK_FRAMES = 4;

    // Receive lock states, Gray along hunt, track, locked
    typedef enum logic [1:0]
    {
        RX_HUNT = 2'b00,
        RX_TRACK = 2'b01,
        RX_LOCKED = 2'b11
    } sls_rx_state_type;

    // Receiver status handed to the control block
    typedef struct packed
    {
        logic lock_n;
        logic word_valid;
        logic lost;
        logic gained;
        logic [9:0] data;
    } sls_rx_status_type;

endpackage

/* File: design/sls_rx_lock.sv */
// Receive framing, lock detection and relock for the serial link
`timescale 1ns/100ps
module sls_rx_lock
    import sls_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_powered,
    input wire logic i_serial_bit,
    output sls_rx_status_type o_status
);

    sls_rx_state_type state_reg;
    logic [11:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [2:0] good_cnt_reg;
    logic [2:0] bad_cnt_reg;
    logic [9:0] data_reg;
    logic valid_reg;
    logic lost_reg;
    logic gained_reg;
    logic boundary;
    logic frame_ok;
    logic sync_seen;

    // Clock-high first, clock-low last marks a good frame
    assign boundary = (bit_cnt_reg == FRAME_LAST);
    assign frame_ok = shift_reg[FRAME_W-1] & ~shift_reg[0];
    assign sync_seen = (shift_reg == SYNC_FRAME);

    // Bit window, oldest bit on the left
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            shift_reg <= 12'h000;
        else
            shift_reg <= {shift_reg[10:0], i_serial_bit};
    end

    // Lock state machine; powerdown forces a fresh hunt
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= RX_HUNT;
            bit_cnt_reg <= 4'h0;
            good_cnt_reg <= 3'h0;
            bad_cnt_reg <= 3'h0;
            data_reg <= 10'h000;
            valid_reg <= 1'b0;
            lost_reg <= 1'b0;
            gained_reg <= 1'b0;
        end
        else if (!i_powered)
        begin
            state_reg <= RX_HUNT;
            bit_cnt_reg <= 4'h0;
            good_cnt_reg <= 3'h0;
            bad_cnt_reg <= 3'h0;
            valid_reg <= 1'b0;
            lost_reg <= 1'b0;
            gained_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= 1'b0;
            lost_reg <= 1'b0;
            gained_reg <= 1'b0;
            bit_cnt_reg <= boundary ? 4'h0 : bit_cnt_reg + 4'h1;
            case (state_reg)
                RX_HUNT:
                begin
                    // A sync symbol locks at once; otherwise slide one bit per cycle
                    if (sync_seen)
                    begin
                        state_reg <= RX_LOCKED;
                        gained_reg <= 1'b1;
                        bad_cnt_reg <= 3'h0;
                        bit_cnt_reg <= 4'h0;
                    end
                    else if (boundary && frame_ok)
                    begin
                        state_reg <= RX_TRACK;
                        good_cnt_reg <= 3'h1;
                    end
                    else if (boundary)
                        bit_cnt_reg <= FRAME_LAST;
                end
                RX_TRACK:
                begin
                    // Random-data lock needs several good frames in a row
                    if (boundary && !frame_ok)
                    begin
                        state_reg <= RX_HUNT;
                        bit_cnt_reg <= FRAME_LAST;
                    end
                    else if (boundary && good_cnt_reg == 3'(RELOCK_FRAMES - 1))
                    begin
                        state_reg <= RX_LOCKED;
                        gained_reg <= 1'b1;
                        bad_cnt_reg <= 3'h0;
                    end
                    else if (boundary)
                        good_cnt_reg <= good_cnt_reg + 3'h1;
                end
                RX_LOCKED:
                begin
                    if (boundary)
                    begin
                        data_reg <= shift_reg[10:1];
                        valid_reg <= 1'b1;
                        bad_cnt_reg <= frame_ok ? 3'h0 : bad_cnt_reg + 3'h1;
                        // Fourth bad frame in a row drops lock
                        if (!frame_ok && bad_cnt_reg == 3'(LOSS_FRAMES - 1))
                        begin
                            state_reg <= RX_HUNT;
                            lost_reg <= 1'b1;
                            bit_cnt_reg <= FRAME_LAST;
                        end
                    end
                end
                default:
                    state_reg <= RX_HUNT;
            endcase
        end
    end

    assign o_status.lock_n = (state_reg != RX_LOCKED);
    assign o_status.word_valid = valid_reg;
    assign o_status.lost = lost_reg;
    assign o_status.gained = gained_reg;
    assign o_status.data = data_reg;

endmodule // sls_rx_lock

/* File: design/sls_link_ctrl.sv */
// Serial link sync controller: transmit framing, sync symbols, APB registers
//
// Contract
// - Lock is declared lost only after 4 consecutive frames with bad clock bits.
// - After loss, lock returns via resent sync symbols or slower random-data lock.
// - Each active transmit clock edge captures the 10 data pins into a register.
// - Edge-select high captures on rising transmit clock, low on falling.
// - Both serial outputs float while the serial output enable is low.
// - Powerdown low stops the transmitter, floats outputs and sleeps.
// - A sync request starts at least 1024 sync symbols on the serial output.
// - Sync symbols continue as long as the request stays high.
// - The effective sync request is the OR of the two request inputs and the control soft-sync bit.
// - Undriven test data, mode select and reset inputs read as high.
// - The lock indicator is high while unlocked and low once locked.
// - Two clock bits are embedded in every serialized word.
`timescale 1ns/100ps
module sls_link_ctrl
    import sls_pkg::*;
#(
    parameter int SYNC_MIN = SYNC_MIN_SYMBOLS
)
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq,
    // Transmit pins
    input wire logic i_transmit_clock_in,
    input wire logic i_tx_edge_select,
    input wire logic i_serial_output_enable,
    input wire logic i_powerdown_n,
    input wire logic [9:0] i_tx_data,
    input wire logic i_sync_req_a,
    input wire logic i_sync_req_b,
    output logic o_serial_p,
    output logic o_serial_n,
    output logic o_serial_oe,
    // Receive pins
    input wire logic i_serial_rx,
    output logic o_lock_n,
    output logic o_lock_n_oe,
    output logic [9:0] o_parallel_data_out,
    output logic o_rx_word_valid,
    // Test inputs: value and whether anything drives them
    input wire logic [2:0] i_test_pin,
    input wire logic [2:0] i_test_pin_driven,
    output logic [2:0] o_test_level
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int PIN_W = 17;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic s_transmit_clock_in;
    logic s_edge_sel;
    logic s_oe;
    logic s_powered;
    logic s_sync_a;
    logic s_sync_b;
    logic s_rx;
    logic [9:0] s_data;

    assign pin_raw = {i_transmit_clock_in, i_tx_edge_select, i_serial_output_enable,
        i_powerdown_n, i_sync_req_a, i_sync_req_b, i_serial_rx, i_tx_data};

    // Two stages; only the second stage is read by logic
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_meta_reg <= 17'h00000;
            pin_sync_reg <= 17'h00000;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign s_transmit_clock_in = pin_sync_reg[16];
    assign s_edge_sel = pin_sync_reg[15];
    assign s_oe = pin_sync_reg[14];
    assign s_powered = pin_sync_reg[13];
    assign s_sync_a = pin_sync_reg[12];
    assign s_sync_b = pin_sync_reg[11];
    assign s_rx = pin_sync_reg[10];
    assign s_data = pin_sync_reg[9:0];

    ////////////////////////////////////////////////////////////////////////////
    // Registers and APB decode

    logic [CTRL_W-1:0] ctrl_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    logic setup;
    logic access;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_stat;
    logic mapped;
    logic [IRQ_W-1:0] irq_events;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS)
        || (i_paddr == ADDR_IRQ_STAT) || (i_paddr == ADDR_IRQ_MASK)
        || (i_paddr == ADDR_RX_DATA) || (i_paddr == ADDR_TX_DATA);
    assign wr_ctrl = access & i_pwrite & (i_paddr == ADDR_CTRL);
    assign wr_mask = access & i_pwrite & (i_paddr == ADDR_IRQ_MASK);
    assign rd_stat = access & ~i_pwrite & (i_paddr == ADDR_IRQ_STAT);

    // Zero wait states; an unmapped address answers with an error
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;
    assign o_prdata = prdata_reg;

    // Writable control and mask
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_reg <= CTRL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= i_pwdata[CTRL_W-1:0];
            if (wr_mask)
                irq_mask_reg <= i_pwdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit clock edge finding and word capture

    logic transmit_clock_in_prev_reg;
    logic transmit_clock_in_rise;
    logic transmit_clock_in_fall;
    logic capture;
    logic [9:0] tx_word_reg;
    logic tx_word_evt_reg;

    // Edges found on the synchronised copy, one sample late
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            transmit_clock_in_prev_reg <= 1'b0;
        else
            transmit_clock_in_prev_reg <= s_transmit_clock_in;
    end

    assign transmit_clock_in_rise = s_transmit_clock_in & ~transmit_clock_in_prev_reg;
    assign transmit_clock_in_fall = ~s_transmit_clock_in & transmit_clock_in_prev_reg;
    assign capture = s_powered & (s_edge_sel ? transmit_clock_in_rise : transmit_clock_in_fall);

    // Data must stay stable for two system clocks around the edge
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_word_reg <= 10'h000;
            tx_word_evt_reg <= 1'b0;
        end
        else
        begin
            tx_word_evt_reg <= capture;
            if (capture)
                tx_word_reg <= s_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync request and minimum symbol count

    logic sync_req;
    logic sync_req_prev_reg;
    logic [SYNC_CNT_W-1:0] sync_left_reg;
    logic send_sync;
    logic frame_load;

    assign sync_req = s_sync_a | s_sync_b | ctrl_reg[CTRL_SOFT_SYNC_BIT];
    assign send_sync = sync_req | (sync_left_reg != 11'h000);

    // A new request reloads the count; each sent symbol takes one off
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync_req_prev_reg <= 1'b0;
            sync_left_reg <= 11'h000;
        end
        else if (!s_powered)
        begin
            sync_req_prev_reg <= 1'b0;
            sync_left_reg <= 11'h000;
        end
        else
        begin
            sync_req_prev_reg <= sync_req;
            if (sync_req && !sync_req_prev_reg)
                sync_left_reg <= SYNC_CNT_W'(SYNC_MIN);
            else if (frame_load && sync_left_reg != 11'h000)
                sync_left_reg <= sync_left_reg - 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame serialiser

    logic [11:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic [11:0] next_frame;

    assign frame_load = (tx_cnt_reg == FRAME_LAST);
    // Clock bits frame every word; sync symbol replaces data when asked
    assign next_frame = send_sync ? SYNC_FRAME : {1'b1, tx_word_reg, 1'b0};

    // One bit per system clock, MSB first; halts in powerdown
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_shift_reg <= 12'h000;
            tx_cnt_reg <= FRAME_LAST;
        end
        else if (!s_powered)
        begin
            tx_shift_reg <= 12'h000;
            tx_cnt_reg <= FRAME_LAST;
        end
        else if (frame_load)
        begin
            tx_shift_reg <= next_frame;
            tx_cnt_reg <= 4'h0;
        end
        else
        begin
            tx_shift_reg <= {tx_shift_reg[10:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
        end
    end

    // Registered pin drive; float when disabled or powered down
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_serial_p <= 1'b0;
            o_serial_n <= 1'b1;
            o_serial_oe <= 1'b0;
        end
        else
        begin
            o_serial_p <= tx_shift_reg[FRAME_W-1];
            o_serial_n <= ~tx_shift_reg[FRAME_W-1];
            o_serial_oe <= s_oe & s_powered;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver

    sls_rx_status_type rx_status;
    logic rx_bit;

    // Loopback lets software check the framing without a partner
    assign rx_bit = ctrl_reg[CTRL_LOOPBACK_BIT] ? tx_shift_reg[FRAME_W-1] : s_rx;

    sls_rx_lock u_rx_lock
    (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_powered(s_powered),
        .i_serial_bit(rx_bit),
        .o_status(rx_status)
    );

    // Lock pin floats in powerdown; stays high otherwise until locked
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_lock_n <= 1'b1;
            o_lock_n_oe <= 1'b0;
            o_parallel_data_out <= 10'h000;
            o_rx_word_valid <= 1'b0;
        end
        else
        begin
            o_lock_n <= rx_status.lock_n;
            o_lock_n_oe <= s_powered;
            o_rx_word_valid <= rx_status.word_valid;
            if (rx_status.word_valid)
                o_parallel_data_out <= rx_status.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, cleared by reading, a new event beats the clear

    always_comb
    begin
        irq_events = '0;
        irq_events[IRQ_LOST_BIT] = rx_status.lost;
        irq_events[IRQ_GAINED_BIT] = rx_status.gained;
        irq_events[IRQ_RX_WORD_BIT] = rx_status.word_valid;
        irq_events[IRQ_TX_WORD_BIT] = tx_word_evt_reg;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            irq_stat_reg <= 4'h0;
        else if (rd_stat)
            irq_stat_reg <= (irq_stat_reg & ~prdata_reg[IRQ_W-1:0]) | irq_events;
        else
            irq_stat_reg <= irq_stat_reg | irq_events;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_stat_reg & irq_mask_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup phase, ready for the access phase

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            prdata_reg <= 32'h00000000;
        else if (setup && !i_pwrite)
        begin
            prdata_reg <= 32'h00000000;
            case (i_paddr)
                ADDR_CTRL:
                    prdata_reg[CTRL_W-1:0] <= ctrl_reg;
                ADDR_STATUS:
                begin
                    prdata_reg[STAT_LOCK_N_BIT] <= rx_status.lock_n;
                    prdata_reg[STAT_SYNC_BIT] <= send_sync;
                    prdata_reg[STAT_POWERED_BIT] <= s_powered;
                    prdata_reg[STAT_OE_BIT] <= o_serial_oe;
                end
                ADDR_IRQ_STAT:
                    prdata_reg[IRQ_W-1:0] <= irq_stat_reg;
                ADDR_IRQ_MASK:
                    prdata_reg[IRQ_W-1:0] <= irq_mask_reg;
                ADDR_RX_DATA:
                    prdata_reg[DATA_W-1:0] <= rx_status.data;
                ADDR_TX_DATA:
                    prdata_reg[DATA_W-1:0] <= tx_word_reg;
                default:
                    prdata_reg <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test inputs: modelled pull-ups when nothing drives them

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pullup
            assign o_test_level[gi] = i_test_pin_driven[gi] ? i_test_pin[gi] : 1'b1;
        end
    endgenerate

endmodule // sls_link_ctrl

/* File: sim/sls_link_ctrl_chk.sv */
// Port-level assertion checker for the serial link sync controller
`timescale 1ns/100ps
module sls_link_ctrl_chk (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_powerdown_n,
    input wire logic i_serial_output_enable,
    input wire logic i_sync_req_a,
    input wire logic i_sync_req_b,
    input wire logic [2:0] i_test_pin,
    input wire logic [2:0] i_test_pin_driven,
    input wire logic o_serial_p,
    input wire logic o_serial_n,
    input wire logic o_serial_oe,
    input wire logic o_lock_n,
    input wire logic o_lock_n_oe,
    input wire logic o_rx_word_valid,
    input wire logic [2:0] o_test_level
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////////////
    // Run length on the line; may overcount by one as the driver turns on
    logic [3:0] run_reg;
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            run_reg <= 4'h0;
        else if (!o_serial_oe || (o_serial_p != $past(o_serial_p)))
            run_reg <= 4'h0;
        else
            run_reg <= run_reg + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_SERIAL_DIFF: assert property (o_serial_oe |-> o_serial_n == !o_serial_p)
        else $error("serial pair not complementary");
    AST_OE_FLOAT: assert property (!i_serial_output_enable [*4] |-> !o_serial_oe)
        else $error("serial driven while disabled");
    AST_POWERDOWN_N_FLOAT:
        assert property (!i_powerdown_n [*4] |-> !o_serial_oe && !o_lock_n_oe)
        else $error("outputs driven in powerdown");
    AST_TEST_PULL:
        assert property (o_test_level == (i_test_pin | ~i_test_pin_driven))
        else $error("test input level wrong");
    AST_RUN_LIMIT: assert property (run_reg < 4'hC)
        else $error("no embedded clock edge in a frame");
    AST_WORD_GAP: assert property (o_rx_word_valid |=> !o_rx_word_valid [*8])
        else $error("received words closer than a frame");
    AST_LOCK_HOLD: assert property ($fell(o_lock_n) |=> !o_lock_n [*8])
        else $error("lock dropped too soon");
    AST_SYNC_START:
        assert property ($rose(i_sync_req_a || i_sync_req_b) && o_serial_oe |->
            ##[1:40] o_serial_p [*5] ##1 !o_serial_p [*7] ##1 o_serial_p)
        else $error("no sync symbol after request");

    // Main scenarios reached
    COV_LOCK: cover property ($fell(o_lock_n));
    COV_LOSS: cover property ($rose(o_lock_n));
    COV_WORD: cover property (o_rx_word_valid);
endmodule // sls_link_ctrl_chk

bind sls_link_ctrl sls_link_ctrl_chk u_chk (.*);

/* File: sim/sls_far_end.sv */
// Far-end model that feeds framed serial bits to the receive pin
`timescale 1ns/100ps
module sls_far_end
    import sls_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [1:0] i_mode,
    output logic o_bit,
    output logic o_frame_end
);
    logic [3:0] pos_reg = 4'h0;
    logic [11:0] frame;

    ////////////////////////////////////////////////////////////////////////////
    // Frame per mode; idle line sits low and never looks framed
    always_comb
    begin
        case (i_mode)
            2'h1: frame = SYNC_FRAME;
            2'h2: frame = 12'h8A6;
            2'h3: frame = 12'h4A5;
            default: frame = 12'h000;
        endcase
    end

    // Bit position, one bit per system clock, MSB first
    always_ff @(posedge i_clk_sys)
    begin
        pos_reg <= (pos_reg == FRAME_LAST) ? 4'h0 : pos_reg + 4'h1;
    end
    assign o_bit = frame[FRAME_LAST - pos_reg];
    assign o_frame_end = (pos_reg == FRAME_LAST);
endmodule // sls_far_end

/* File: sim/sls_link_ctrl_bench.sv */
// Self-checking bench for the serial link sync controller
`timescale 1ns/100ps
module sls_link_ctrl_bench
    import sls_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_transmit_clock_in = 1'b0;
    logic i_tx_edge_select = 1'b1;
    logic i_serial_output_enable = 1'b1;
    logic i_powerdown_n = 1'b1;
    logic [9:0] i_tx_data = 10'h155;
    logic i_sync_req_a = 1'b0;
    logic i_sync_req_b = 1'b0;
    logic [2:0] i_test_pin = 3'h0;
    logic [2:0] i_test_pin_driven = 3'h0;
    logic i_serial_rx;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq, o_serial_p, o_serial_n, o_serial_oe;
    logic o_lock_n, o_lock_n_oe, o_rx_word_valid;
    logic [9:0] o_parallel_data_out;
    logic [2:0] o_test_level;
    logic [2:0] cnt = 3'h0;
    logic [1:0] mode = 2'h0;
    logic fend, err;
    logic [31:0] v;
    int num_errors = 0;
    int num_checks = 0;

    sls_link_ctrl #(.SYNC_MIN(8)) dut (.*);
    sls_far_end u_far (.i_clk_sys(i_clk_sys), .i_mode(mode), .o_bit(i_serial_rx),
        .o_frame_end(fend));

    always #50 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    // Link clock of eight system clocks; locked phase keeps edge checks exact
    always @(posedge i_clk_sys)
    begin
        cnt <= cnt + 3'h1;
        i_transmit_clock_in <= (cnt == 3'h7) || (cnt < 3'h3);
        if (cnt == 3'h1)
            i_tx_data <= i_tx_data + 10'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits one edge first so strobes never toggle twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        v = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // Switch the far end only at a frame boundary
    task automatic far_mode(input logic [1:0] m);
        do @(posedge i_clk_sys); while (fend !== 1'b1);
        mode <= m;
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the roughly one thousand cycles the tests need
    initial
    begin
        repeat (8000) @(posedge i_clk_sys);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        for (int k = 0; k < 64; k++)
        begin
            i_test_pin_driven <= k[5:3];
            i_test_pin <= k[2:0];
            @(posedge i_clk_sys);
            chk(o_test_level, 3'(k[2:0] | ~k[5:3]), "test level");
        end
        for (int s = 0; s < 2; s++)
        begin
            i_tx_edge_select <= s[0];
            repeat (20) @(posedge i_clk_sys);
            do @(posedge i_clk_sys); while (cnt !== 3'h6);
            apb(1'b0, ADDR_TX_DATA, 32'h0);
            chk(v, {22'h0, s ? i_tx_data - 10'h1 : i_tx_data}, "tx word");
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({v[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, ADDR_IRQ_MASK, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h3);
        repeat (60) @(posedge i_clk_sys);
        chk(o_lock_n, 1'b0, "lock pin");
        chk(o_irq, 1'b1, "irq raised");
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(v & 32'h3, 32'h2, "irq status");
        repeat (3) @(posedge i_clk_sys);
        chk(o_irq, 1'b0, "irq cleared");
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (150) @(posedge i_clk_sys);
        i_sync_req_a <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        i_sync_req_a <= 1'b0;
        repeat (40) @(posedge i_clk_sys);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(v[STAT_SYNC_BIT], 1'b1, "sync minimum");
        repeat (150) @(posedge i_clk_sys);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(v[STAT_SYNC_BIT], 1'b0, "sync ended");
        i_sync_req_b <= 1'b1;
        repeat (200) @(posedge i_clk_sys);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(v[STAT_SYNC_BIT], 1'b1, "sync held");
        i_sync_req_b <= 1'b0;
        far_mode(2'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (150) @(posedge i_clk_sys);
        chk(o_lock_n, 1'b0, "far lock");
        far_mode(2'h2);
        repeat (40) @(posedge i_clk_sys);
        chk(o_parallel_data_out, 10'h053, "rx word");
        far_mode(2'h3);
        repeat (46) @(posedge i_clk_sys);
        chk(o_lock_n, 1'b0, "three bad frames");
        repeat (14) @(posedge i_clk_sys);
        chk(o_lock_n, 1'b1, "four bad frames");
        far_mode(2'h1);
        repeat (40) @(posedge i_clk_sys);
        chk(o_lock_n, 1'b0, "relock");
        i_serial_output_enable <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        chk(o_serial_oe, 1'b0, "serial float");
        i_serial_output_enable <= 1'b1;
        i_powerdown_n <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        chk({o_serial_oe, o_lock_n_oe}, 2'h0, "powerdown");
        i_powerdown_n <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        chk(o_serial_oe, 1'b1, "serial driven");
        tally_and_finish();
    end
endmodule // sls_link_ctrl_bench
